// *** sfwc_flash_end.sv ***
// Flash device end: serial decode, write latch, page buffer and internal cycles.
`timescale 1ns/1ns
module sfwc_flash_end
	import sfwc_pkg::*;
#(
	parameter int NPAGES            = 4,
	parameter int PAGE_REWRITE_US   = PAGE_REWRITE_TIME_US,
	parameter int PAGE_PROGRAM_US   = PAGE_PROGRAM_TIME_US,
	parameter int PAGE_ERASE_US     = PAGE_ERASE_TIME_US,
	parameter int SECTOR_ERASE_US   = SECTOR_ERASE_TIME_US,
	parameter int POWERUP_DELAY_US  = POWERUP_WRITE_DELAY_US
)(
	input  wire logic              mclk,
	input  wire logic              resetn,
	sfwc_link_if.dev               link,
	input  wire logic [$clog2(NPAGES*PAGE_BYTES)-1:0] peekAddr,
	output logic      [7:0]        peekData,
	output logic      [7:0]        statusByte,
	output logic                   activeMode,
	output logic                   deepSleep,
	output logic                   writeReady
);

	localparam int NBYTES = NPAGES * PAGE_BYTES;
	localparam int PGW = $clog2(NPAGES);
	localparam int NSECT = (NBYTES + SECTOR_BYTES - 1) / SECTOR_BYTES;
	localparam int CYC_REWRITE = PAGE_REWRITE_US * CLK_MHZ;
	localparam int CYC_PROGRAM = PAGE_PROGRAM_US * CLK_MHZ;
	localparam int CYC_PG_ERASE = PAGE_ERASE_US * CLK_MHZ;
	localparam int CYC_SC_ERASE = SECTOR_ERASE_US * CLK_MHZ;
	localparam int CYC_PUW = POWERUP_DELAY_US * CLK_MHZ;

	typedef enum logic [1:0] {
		D_IDLE = 2'b01,
		D_BUSY = 2'b10
	} sfwc_cyc_t;

	typedef struct packed {
		sfwc_cyc_t                   cyc;
		logic [PIN_COUNT-1:0]        meta;
		logic [PIN_COUNT-1:0]        sync;
		logic                        sckPrev;
		logic                        csPrev;
		logic [2:0]                  bitCnt;
		logic [2:0]                  byteCnt;
		logic [7:0]                  shiftIn;
		logic [7:0]                  shiftOut;
		logic [7:0]                  opcode;
		logic [23:0]                 addr;
		logic [7:0]                  dataIdx;
		logic                        frameDrop;
		logic                        latch;
		logic                        sleep;
		logic                        puDone;
		logic [31:0]                 puCnt;
		logic [31:0]                 timer;
		logic [7:0]                  cycOp;
		logic                        miso;
		logic                        misoOeN;
		logic [7:0]                  peek;
		logic [PAGE_BYTES-1:0]       touched;
		logic [PAGE_BYTES-1:0][7:0]  pbuf;
		logic [NBYTES-1:0][7:0]      mem;
	} sfwc_dev_t;

	sfwc_dev_t s;
	sfwc_dev_t next_s;

	// ----------------------------------------------------------------
	// Decoded pin events
	// ----------------------------------------------------------------
	logic       sckS;
	logic       csS;
	logic       mosiS;
	logic       rstS;
	logic       wpS;
	logic       busy;
	logic       sckRise;
	logic       sckFall;
	logic       csFall;
	logic       csRise;
	logic       resetMode;
	logic [7:0] byteIn;
	logic [7:0] statusNow;
	logic       protHit;
	logic       modifyOk;
	logic       statusOut;
	logic [7:0] bufIdx;
	int         pageSel;
	int         sectSel;

	assign sckS = s.sync[PIN_SCK];
	assign csS = s.sync[PIN_CS];
	assign mosiS = s.sync[PIN_MOSI];
	assign rstS = s.sync[PIN_RST];
	assign wpS = s.sync[PIN_WP];
	assign busy = (s.cyc == D_BUSY);                          // see R7
	assign sckRise = sckS & ~s.sckPrev;
	assign sckFall = ~sckS & s.sckPrev;
	assign csFall = ~csS & s.csPrev;
	assign csRise = csS & ~s.csPrev;
	// A running cycle keeps going while the reset pin is low
	assign resetMode = ~rstS & ~busy;                         // see R20
	assign byteIn = {s.shiftIn[6:0], mosiS};
	// Flags are built from internal state only; no command writes them
	assign statusNow = STATUS_RESET
		| (8'(s.latch) << STATUS_LATCH_BIT)
		| (8'(busy) << STATUS_BUSY_BIT);                      // see R9, R10
	assign protHit = ~wpS & (s.addr[23:16] == PROT_TOP_BYTE); // see R17
	assign modifyOk = s.latch & ~s.sleep & ~busy & s.puDone & ~protHit; // see R23, R19
	assign statusOut = (s.opcode == CMD_STATUS_READ) && (s.byteCnt != 3'h0) && !s.sleep;
	assign bufIdx = s.addr[7:0] + s.dataIdx;                  // see R2
	assign pageSel = int'(s.addr[8 +: PGW]);
	assign sectSel = int'(s.addr[23:16]) % NSECT;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.meta = {link.wpN, link.rstPinN, link.mosi, link.csN, link.sck};
		next_s.sync = s.meta;
		next_s.sckPrev = sckS;
		next_s.csPrev = csS;
		next_s.peek = s.mem[peekAddr];

		// Startup delay before any modification is accepted
		if (!s.puDone) begin
			next_s.puCnt = s.puCnt + 32'h1;
			if (s.puCnt >= 32'(CYC_PUW) - 32'h1) begin
				next_s.puDone = 1'b1;                             // see R19
			end
		end

		// Internal cycle: the array is updated at the end of the timed cycle
		if (busy) begin
			next_s.timer = s.timer - 32'h1;
			if (s.timer <= 32'h1) begin
				next_s.cyc = D_IDLE;                              // see R7
				for (int i = 0; i < NBYTES; i++) begin
					unique case (s.cycOp)
						CMD_PAGE_REWRITE: begin
							// Merge untouched bytes, erase, then program the page
							if (i / PAGE_BYTES == pageSel && s.touched[i % PAGE_BYTES]) begin
								next_s.mem[i] = s.pbuf[i % PAGE_BYTES]; // see R5
							end
						end
						CMD_PAGE_PROGRAM: begin
							if (i / PAGE_BYTES == pageSel && s.touched[i % PAGE_BYTES]) begin
								next_s.mem[i] = s.mem[i] & s.pbuf[i % PAGE_BYTES]; // see R6
							end
						end
						CMD_PAGE_ERASE: begin
							if (i / PAGE_BYTES == pageSel) begin
								next_s.mem[i] = ERASED_BYTE;
							end
						end
						default: begin
							if (i / SECTOR_BYTES == sectSel) begin
								next_s.mem[i] = ERASED_BYTE;
							end
						end
					endcase
				end
			end
		end

		// Serial frame handling
		if (resetMode) begin
			next_s.latch = 1'b0;                                  // see R16
			next_s.misoOeN = 1'b1;
			next_s.frameDrop = 1'b1;
			next_s.bitCnt = 3'h0;
			next_s.byteCnt = 3'h0;
		end else if (csFall) begin
			next_s.bitCnt = 3'h0;
			next_s.byteCnt = 3'h0;
			next_s.frameDrop = 1'b0;
		end else if (!csS && !s.frameDrop) begin
			if (sckRise) begin
				next_s.shiftIn = byteIn;
				next_s.bitCnt = s.bitCnt + 3'h1;
				if (s.bitCnt == 3'(BYTE_BITS - 1)) begin
					if (s.byteCnt != 3'h7) begin
						next_s.byteCnt = s.byteCnt + 3'h1;
					end
					if (s.byteCnt == 3'h0) begin
						next_s.opcode = byteIn;
						next_s.shiftOut = statusNow;
						// A new buffer load must not disturb a running merge
						if (!busy) begin
							next_s.dataIdx = 8'h00;
							next_s.touched = '0;
						end
					end else if (s.byteCnt <= 3'(ADDR_BYTES)) begin
						next_s.addr = {s.addr[15:0], byteIn};
						next_s.shiftOut = statusNow;
					end else begin
						next_s.shiftOut = statusNow;              // Continuous status polling
						if ((s.opcode == CMD_PAGE_REWRITE || s.opcode == CMD_PAGE_PROGRAM)
								&& !busy && !s.sleep) begin       // see R22, R13
							next_s.pbuf[bufIdx] = byteIn;         // see R4
							next_s.touched[bufIdx] = 1'b1;
							next_s.dataIdx = s.dataIdx + 8'h1;
						end
					end
				end
			end
			if (sckFall && statusOut) begin
				next_s.miso = s.shiftOut[7];
				next_s.shiftOut = {s.shiftOut[6:0], 1'b0};
				next_s.misoOeN = 1'b0;
			end
		end

		// Commands act on select rising, only at a byte boundary
		if (csS) begin
			next_s.misoOeN = 1'b1;
		end
		if (csRise && !resetMode && !s.frameDrop && s.bitCnt == 3'h0
				&& s.byteCnt != 3'h0) begin                       // see R14, R21
			unique case (s.opcode)
				CMD_WAKE: next_s.sleep = 1'b0;                    // see R12
				CMD_WRITE_LATCH_SET: begin
					if (!s.sleep) next_s.latch = 1'b1;            // see R13
				end
				CMD_WRITE_LATCH_CLEAR: begin
					if (!s.sleep) next_s.latch = 1'b0;            // see R16
				end
				CMD_DEEP_SLEEP: begin
					if (!busy) next_s.sleep = 1'b1;               // see R12
				end
				CMD_PAGE_REWRITE, CMD_PAGE_PROGRAM: begin
					if (modifyOk && s.byteCnt > 3'(HEADER_BYTES)) begin
						next_s.cyc = D_BUSY;                      // see R5
						next_s.cycOp = s.opcode;
						next_s.timer = (s.opcode == CMD_PAGE_REWRITE) ?
							32'(CYC_REWRITE) : 32'(CYC_PROGRAM);
						next_s.latch = 1'b0;                      // see R16
					end
				end
				CMD_PAGE_ERASE, CMD_SECTOR_ERASE: begin
					if (modifyOk && s.byteCnt == 3'(HEADER_BYTES)) begin
						next_s.cyc = D_BUSY;
						next_s.cycOp = s.opcode;
						next_s.timer = (s.opcode == CMD_PAGE_ERASE) ?
							32'(CYC_PG_ERASE) : 32'(CYC_SC_ERASE);
						next_s.latch = 1'b0;                      // see R16
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Power-on reset: latch clear, array erased, startup delay restarts
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
			s.cyc <= D_IDLE;
			s.meta <= ~(PIN_COUNT'(1) << PIN_SCK);          // Clock idles low, no false edge
			s.sync <= ~(PIN_COUNT'(1) << PIN_SCK);
			s.sckPrev <= 1'b0;
			s.csPrev <= 1'b1;
			s.frameDrop <= 1'b1;
			s.misoOeN <= 1'b1;
			s.mem <= {NBYTES{ERASED_BYTE}};
		end else begin
			s <= next_s;
		end
	end

	assign link.miso = s.miso;
	assign link.misoOeN = s.misoOeN;
	assign peekData = s.peek;
	assign statusByte = statusNow;
	assign activeMode = ~csS | busy;                          // see R11
	assign deepSleep = s.sleep;
	assign writeReady = s.puDone;

endmodule // sfwc_flash_end

// *** sfwc_pkg.sv ***
// Shared constants of the serial flash write-control link, device end and host end.
//
// Overview of operation
// R1 - Host sends latch-set, then four-byte header plus data
// R2 - Up to 256 data bytes, one page, consecutive
// R3 - Page rewrite: select low, opcode, address, data, select high
// R4 - Data bytes fill buffer from low address byte
// R5 - Select rise starts merge, erase, program of page
// R6 - Page program only clears bits to zero
// R7 - Cycle-active flag true exactly during internal cycles
// R8 - Host may poll status until cycle-active clears
// R9 - Status: zeros above, latch bit 1, busy bit 0
// R10 - Status flags volatile, not host writable
// R11 - Active while selected or busy, else standby
// R12 - Deep-sleep command enters power-down until wake command
// R13 - In power-down only the wake command is obeyed
// R14 - Modifying commands need clock count multiple of eight
// R15 - Host sets write latch before every modifying command
// R16 - Latch cleared by reset, clear command, modify completion; the code clears it when the internal cycle starts
// R17 - Write-protect low guards lowest 256 pages
// R18 - Host holds reset pin low through power-on
// R19 - Power-up delay blocks all modifications until elapsed
// R20 - Reset pin low idles device unless cycle runs
// R21 - Commands end exactly on byte boundary or rejected
// R22 - Array accesses ignored while an internal cycle runs
// R23 - Modify command with latch clear is discarded
package sfwc_pkg;

	localparam int CLK_MHZ = 20;
	localparam int BYTE_BITS = 8;
	localparam int PAGE_BYTES = 256;
	localparam int SECTOR_BYTES = 65536;
	localparam int HEADER_BYTES = 4;
	localparam int ADDR_BYTES = 3;

	// One-byte command codes
	localparam logic [7:0] CMD_WRITE_LATCH_SET = 8'h06;
	localparam logic [7:0] CMD_WRITE_LATCH_CLEAR = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ = 8'h05;
	localparam logic [7:0] CMD_PAGE_REWRITE = 8'h0a;
	localparam logic [7:0] CMD_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] CMD_PAGE_ERASE = 8'hdb;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'hd8;
	localparam logic [7:0] CMD_DEEP_SLEEP = 8'hb9;
	localparam logic [7:0] CMD_WAKE = 8'hab;

	// Status byte layout
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_LATCH_BIT = 1;
	localparam logic [7:0] STATUS_RESET = 8'h00;

	// Lowest 256 pages are the addresses whose top byte is zero
	localparam logic [7:0] PROT_TOP_BYTE = 8'h00;
	localparam logic [7:0] ERASED_BYTE = 8'hff;

	// Default internal cycle times, in microseconds
	localparam int PAGE_REWRITE_TIME_US = 100;
	localparam int PAGE_PROGRAM_TIME_US = 20;
	localparam int PAGE_ERASE_TIME_US = 80;
	localparam int SECTOR_ERASE_TIME_US = 200;
	localparam int POWERUP_WRITE_DELAY_US = 50;

	// Positions of the synchronised link pins
	localparam int PIN_SCK = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_MOSI = 2;
	localparam int PIN_RST = 3;
	localparam int PIN_WP = 4;
	localparam int PIN_COUNT = 5;

	// Host serial clock half period in mclk cycles
	localparam int SCK_HALF_CYCLES = 4;

endpackage

// *** sfwc_link_if.sv ***
// Serial link between the host controller end and the flash device end.
`timescale 1ns/1ns
interface sfwc_link_if;
	logic sck;
	logic csN;
	logic mosi;
	logic rstPinN;
	logic wpN;
	logic miso;
	logic misoOeN;
	logic misoLine;

	// Released data line reads high through the board pull-up
	assign misoLine = misoOeN ? 1'b1 : miso;

	modport dev (
		input  sck,
		input  csN,
		input  mosi,
		input  rstPinN,
		input  wpN,
		output miso,
		output misoOeN
	);

	modport host (
		output sck,
		output csN,
		output mosi,
		output rstPinN,
		output wpN,
		input  misoLine
	);
endinterface

// *** sfwc_host_end.sv ***
// Host controller end: data FIFO and serial command sequencer.
`timescale 1ns/1ns
module sfwc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
)(
	input  wire logic             mclk,
	input  wire logic             resetn,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW:0]                 wp;
		logic [AW:0]                 rp;
	} sfwc_fifo_t;

	sfwc_fifo_t s;
	sfwc_fifo_t next_s;
	logic       full;
	logic       empty;

	assign empty = (s.wp == s.rp);
	assign full = (s.wp[AW-1:0] == s.rp[AW-1:0]) && (s.wp[AW] != s.rp[AW]);
	assign inReady = ~full;
	assign outValid = ~empty;
	assign outData = s.mem[s.rp[AW-1:0]];

	// Push and pop may happen in the same cycle
	always_comb begin
		next_s = s;
		if (inValid && !full) begin
			next_s.mem[s.wp[AW-1:0]] = inData;
			next_s.wp = s.wp + (AW+1)'(1);
		end
		if (outReady && !empty) begin
			next_s.rp = s.rp + (AW+1)'(1);
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule // sfwc_fifo

module sfwc_host_end
	import sfwc_pkg::*;
#(
	parameter int HALF = SCK_HALF_CYCLES,
	parameter int FIFO_DEPTH = 16
)(
	input  wire logic        mclk,
	input  wire logic        resetn,
	sfwc_link_if.host        link,
	input  wire logic        cmdValid,
	output logic             cmdReady,
	input  wire logic [7:0]  cmdOpcode,
	input  wire logic [23:0] cmdAddr,
	input  wire logic        cmdHasAddr,
	input  wire logic [8:0]  cmdDataLen,
	input  wire logic [7:0]  cmdReadLen,
	input  wire logic [2:0]  cmdExtraBits,
	input  wire logic        wrValid,
	output logic             wrReady,
	input  wire logic [7:0]  wrData,
	output logic             rdValid,
	output logic      [7:0]  rdData,
	input  wire logic        resetPinN,
	input  wire logic        writeProtectN,
	output logic             busy
);

	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_LOAD = 5'b00010,
		H_LOW  = 5'b00100,
		H_HIGH = 5'b01000,
		H_END  = 5'b10000
	} sfwc_hst_t;

	typedef struct packed {
		sfwc_hst_t   fsm;
		logic [15:0] phase;
		logic        opLeft;
		logic [1:0]  addrLeft;
		logic [8:0]  dataLeft;
		logic [7:0]  readLeft;
		logic [2:0]  extra;
		logic [7:0]  opcode;
		logic [23:0] addr;
		logic [7:0]  shiftOut;
		logic [7:0]  shiftIn;
		logic [3:0]  bitsLeft;
		logic        isRead;
		logic        sck;
		logic        csN;
		logic        mosi;
		logic        rstPinN;
		logic        wpN;
		logic        meta;
		logic        misoS;
		logic        rdValid;
		logic [7:0]  rdData;
	} sfwc_host_t;

	sfwc_host_t s;
	sfwc_host_t next_s;
	logic       fifoValid;
	logic       fifoPop;
	logic [7:0] fifoData;
	logic       phaseDone;

	// Data bytes wait here so the sequencer can stall on an empty FIFO
	sfwc_fifo #(
		.WIDTH(8),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.mclk     (mclk),
		.resetn   (resetn),
		.inValid  (wrValid),
		.inReady  (wrReady),
		.inData   (wrData),
		.outValid (fifoValid),
		.outReady (fifoPop),
		.outData  (fifoData)
	);

	assign fifoPop = (s.fsm == H_LOAD) && !s.opLeft && (s.addrLeft == 2'h0)
		&& (s.dataLeft != 9'h0);
	assign phaseDone = (s.phase >= 16'(HALF - 1));

	// ----------------------------------------------------------------
	// Sequencer: opcode, address, data, read bytes, then stray bits
	// ----------------------------------------------------------------
	always_comb begin
		next_s = s;
		next_s.meta = link.misoLine;
		next_s.misoS = s.meta;
		next_s.rstPinN = resetPinN;                           // see R18
		next_s.wpN = writeProtectN;
		next_s.rdValid = 1'b0;
		next_s.phase = s.phase + 16'h1;
		unique case (s.fsm)
			H_IDLE: begin
				next_s.phase = 16'h0;
				if (cmdValid) begin
					next_s.fsm = H_LOAD;
					next_s.csN = 1'b0;                            // see R3
					next_s.opLeft = 1'b1;
					next_s.opcode = cmdOpcode;
					next_s.addr = cmdAddr;
					next_s.addrLeft = cmdHasAddr ? 2'(ADDR_BYTES) : 2'h0; // see R1
					next_s.dataLeft = cmdDataLen;                 // see R2
					next_s.readLeft = cmdReadLen;
					next_s.extra = cmdExtraBits;
				end
			end
			H_LOAD: begin
				next_s.phase = 16'h0;
				next_s.bitsLeft = 4'(BYTE_BITS);
				next_s.isRead = 1'b0;
				next_s.fsm = H_LOW;
				if (s.opLeft) begin
					next_s.shiftOut = s.opcode;
					next_s.opLeft = 1'b0;
				end else if (s.addrLeft != 2'h0) begin
					next_s.shiftOut = s.addr[23:16];
					next_s.addr = {s.addr[15:0], 8'h00};
					next_s.addrLeft = s.addrLeft - 2'h1;
				end else if (s.dataLeft != 9'h0) begin
					if (fifoValid) begin
						next_s.shiftOut = fifoData;
						next_s.dataLeft = s.dataLeft - 9'h1;
					end else begin
						next_s.fsm = H_LOAD;                      // Stall on empty FIFO
					end
				end else if (s.readLeft != 8'h0) begin
					next_s.shiftOut = 8'h00;
					next_s.isRead = 1'b1;
					next_s.readLeft = s.readLeft - 8'h1;
				end else if (s.extra != 3'h0) begin
					// Deliberate partial byte, for boundary rejection checks
					next_s.shiftOut = 8'h00;
					next_s.bitsLeft = {1'b0, s.extra};
					next_s.extra = 3'h0;
				end else begin
					next_s.fsm = H_END;
				end
			end
			H_LOW: begin
				next_s.sck = 1'b0;
				next_s.mosi = s.shiftOut[7];
				if (phaseDone) begin
					next_s.fsm = H_HIGH;
					next_s.sck = 1'b1;
					next_s.phase = 16'h0;
				end
			end
			H_HIGH: begin
				// Sample late in the high phase, after the device has settled
				if (phaseDone) begin
					next_s.sck = 1'b0;
					next_s.phase = 16'h0;
					next_s.shiftIn = {s.shiftIn[6:0], s.misoS};
					next_s.shiftOut = {s.shiftOut[6:0], 1'b0};
					next_s.bitsLeft = s.bitsLeft - 4'h1;
					next_s.fsm = H_LOW;
					if (s.bitsLeft == 4'h1) begin
						next_s.fsm = H_LOAD;
						if (s.isRead) begin
							next_s.rdValid = 1'b1;                // see R8
							next_s.rdData = {s.shiftIn[6:0], s.misoS};
						end
					end
				end
			end
			H_END: begin
				next_s.csN = 1'b1;
				next_s.sck = 1'b0;
				if (s.phase >= 16'(2 * HALF - 1)) begin
					next_s.fsm = H_IDLE;
				end
			end
			default: next_s.fsm = H_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
			s.fsm <= H_IDLE;
			s.csN <= 1'b1;
			s.meta <= 1'b1;
			s.misoS <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign cmdReady = (s.fsm == H_IDLE);
	assign busy = (s.fsm != H_IDLE);
	assign rdValid = s.rdValid;
	assign rdData = s.rdData;
	assign link.sck = s.sck;
	assign link.csN = s.csN;
	assign link.mosi = s.mosi;
	assign link.rstPinN = s.rstPinN;
	assign link.wpN = s.wpN;

endmodule // sfwc_host_end

// *** sfwc_link_chk.sv ***
// Concurrent checks on the serial link between the host end and the flash end.
`timescale 1ns/1ns
module sfwc_link_chk (
	input	wire logic	mclk,
	input	wire logic	resetn,
	input	wire logic	sck,
	input	wire logic	csN,
	input	wire logic	mosi,
	input	wire logic	misoOeN
);
	// ----------------------------------------
	// Link timing and release checks
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	// Counts assume the host default of four cycles per half period
	sequence s_high; sck[*4] ##1 !sck; endsequence
	sequence s_desel; csN[*6]; endsequence
	property p_sck_idle; csN |-> !sck; endproperty
	property p_cs_lead; $fell(csN) |-> (!sck)[*5]; endproperty
	property p_sck_high; $rose(sck) |-> s_high; endproperty
	property p_sck_low; $fell(sck) |-> (!sck)[*4]; endproperty
	property p_mosi_hold; $rose(sck) |-> $stable(mosi)[*4]; endproperty
	property p_cs_gap; $rose(csN) |-> csN[*8]; endproperty
	// Six cycles leave room for the device's select synchroniser
	property p_miso_release; s_desel |-> misoOeN; endproperty
	property p_miso_start; $fell(misoOeN) |-> !csN; endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("clock not low when idle");
	a_cs_lead: assert property (p_cs_lead) else $error("clock rose too soon");
	a_sck_high: assert property (p_sck_high) else $error("bad high phase");
	a_sck_low: assert property (p_sck_low) else $error("bad low phase");
	a_mosi_hold: assert property (p_mosi_hold) else $error("data moved in high phase");
	a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
	a_miso_release: assert property (p_miso_release) else $error("data line held");
	a_miso_start: assert property (p_miso_start) else $error("driven while idle");
endmodule // sfwc_link_chk

// *** sfwc_tb.sv ***
// Self-checking bench joining the host end and the flash end over the link.
`timescale 1ns/1ns
module sfwc_tb;
	import sfwc_pkg::*;
	logic		mclk, resetn, cmdValid, cmdReady, cmdHasAddr, wrValid, wrReady, rdValid, busy;
	logic		resetPinN, writeProtectN, activeMode, deepSleep, writeReady;
	logic [7:0]	cmdOpcode, cmdReadLen, wrData, rdData, peekData, statusByte;
	logic [23:0]	cmdAddr;
	logic [8:0]	cmdDataLen, peekAddr;
	logic [2:0]	cmdExtraBits;
	logic [7:0]	expQ[$], dq[$], img[512];
	int		num_errors = 0, comparisons = 0, seed = 32'hcb70;

	// ----------------------------------------
	// Clock, ends and checker
	// ----------------------------------------
	initial begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end
	sfwc_link_if lnk ();
	// Short cycle times keep the run small; still longer than a status read
	sfwc_flash_end #(.NPAGES(2), .PAGE_REWRITE_US(10), .PAGE_PROGRAM_US(10),
		.PAGE_ERASE_US(10), .POWERUP_DELAY_US(25)) sfwc_flash_end_i (
		.mclk(mclk), .resetn(resetn), .link(lnk.dev), .peekAddr(peekAddr),
		.peekData(peekData), .statusByte(statusByte), .activeMode(activeMode),
		.deepSleep(deepSleep), .writeReady(writeReady));
	sfwc_host_end sfwc_host_end_i (.mclk(mclk), .resetn(resetn), .link(lnk.host),
		.cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOpcode(cmdOpcode), .cmdAddr(cmdAddr),
		.cmdHasAddr(cmdHasAddr), .cmdDataLen(cmdDataLen), .cmdReadLen(cmdReadLen),
		.cmdExtraBits(cmdExtraBits), .wrValid(wrValid), .wrReady(wrReady), .wrData(wrData),
		.rdValid(rdValid), .rdData(rdData), .resetPinN(resetPinN),
		.writeProtectN(writeProtectN), .busy(busy));
	sfwc_link_chk sfwc_link_chk_i (.mclk(mclk), .resetn(resetn), .sck(lnk.sck),
		.csN(lnk.csN), .mosi(lnk.mosi), .misoOeN(lnk.misoOeN));

	// ----------------------------------------
	// Compare, drive and finish tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_mem(input int a);
		@(negedge mclk) peekAddr = a[8:0];
		@(negedge mclk) check(peekData, img[a]);
	endtask
	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic ha,
		input logic [8:0] dl, input logic [7:0] rl, input logic [2:0] xb);
		@(negedge mclk);
		while (cmdReady !== 1'b1) @(negedge mclk);
		{cmdOpcode, cmdAddr, cmdHasAddr, cmdDataLen, cmdReadLen} = {op, a, ha, dl, rl};
		cmdExtraBits = xb;
		cmdValid = 1;
		@(negedge mclk) cmdValid = 0;
		@(negedge mclk);
		while (busy !== 1'b0) @(negedge mclk);
	endtask
	task automatic read_status(input int n, input logic [7:0] e);
		repeat (n) expQ.push_back(e);
		cmd(CMD_STATUS_READ, 24'h0, 0, 9'h0, n[7:0], 3'h0);
	endtask
	// A push of sixteen also checks that the full buffer drops wrReady
	task automatic fill(input int n);
		logic [7:0] d;
		repeat (n) begin
			@(negedge mclk);
			d = 8'($random(seed));
			wrValid = 1;
			wrData = d;
			dq.push_back(d);
		end
		@(negedge mclk);
		if (n == 16) check({7'h0, wrReady}, 8'h00);
		wrValid = 0;
	endtask
	task automatic wait_idle;
		while (statusByte[0] !== 1'b0) @(negedge mclk);
	endtask
	task automatic report_and_stop;
		if (expQ.size() != 0) num_errors++;                  // A read that never came back
		$display("comparisons=%0d mismatches=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Read results are matched against the oldest expectation; none means unexpected
	always @(negedge mclk) if (rdValid === 1'b1) begin
		check(rdData, expQ.size() != 0 ? expQ.pop_front() : ~rdData);
	end
	// Cuts a hang short well beyond the expected run length
	initial begin
		#2000000;
		num_errors++;
		report_and_stop();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{resetn, cmdValid, wrValid, cmdOpcode, cmdAddr, cmdHasAddr, wrData, peekAddr} = '0;
		{cmdDataLen, cmdReadLen, cmdExtraBits, resetPinN, writeProtectN} = {20'h0, 2'h3};
		foreach (img[i]) img[i] = ERASED_BYTE;
		repeat (2) @(negedge mclk);
		resetn = 1;
		cmd(CMD_WRITE_LATCH_SET, 24'h0, 0, 9'h0, 8'h0, 3'h0);
		cmd(CMD_PAGE_ERASE, 24'h000100, 1, 9'h0, 8'h0, 3'h0);
		check(statusByte, 8'h02);
		check({7'h0, writeReady}, 8'h00);
		while (writeReady !== 1'b1) @(negedge mclk);
		read_status(2, 8'h02);
		cmd(CMD_WRITE_LATCH_CLEAR, 24'h0, 0, 9'h0, 8'h0, 3'h0);
		read_status(1, 8'h00);
		fill(2);
		cmd(CMD_PAGE_PROGRAM, 24'h000105, 1, 9'h2, 8'h0, 3'h0);
		dq.delete();
		check(statusByte, 8'h00);
		chk_mem(9'h105);
		$display("done: latch and power-up");
		writeProtectN = 0;
		cmd(CMD_WRITE_LATCH_SET, 24'h0, 0, 9'h0, 8'h0, 3'h0);
		fill(16);
		cmd(CMD_PAGE_REWRITE, 24'h0000f8, 1, 9'h10, 8'h0, 3'h0);
		dq.delete();
		check(statusByte, 8'h02);
		writeProtectN = 1;
		fill(16);
		cmd(CMD_PAGE_REWRITE, 24'h0000f8, 1, 9'h10, 8'h0, 3'h0);
		check(statusByte, 8'h01);
		check({7'h0, activeMode}, 8'h01);
		read_status(1, 8'h01);
		wait_idle();
		check({7'h0, activeMode}, 8'h00);
		for (int i = 0; i < 16; i++) img[(248 + i) % 256] = dq.pop_front();
		for (int i = 0; i < 256; i++) chk_mem(i);
		$display("done: protect and rewrite");
		cmd(CMD_WRITE_LATCH_SET, 24'h0, 0, 9'h0, 8'h0, 3'h0);
		fill(16);
		cmd(CMD_PAGE_PROGRAM, 24'h000000, 1, 9'h10, 8'h0, 3'h0);
		wait_idle();
		for (int i = 0; i < 16; i++) img[i] = img[i] & dq.pop_front();
		for (int i = 0; i < 16; i++) chk_mem(i);
		cmd(CMD_WRITE_LATCH_SET, 24'h0, 0, 9'h0, 8'h0, 3'h3);
		check(statusByte, 8'h00);
		cmd(CMD_WRITE_LATCH_SET, 24'h0, 0, 9'h0, 8'h0, 3'h0);
		cmd(CMD_PAGE_ERASE, 24'h000000, 1, 9'h0, 8'h0, 3'h5);
		check(statusByte, 8'h02);
		cmd(CMD_PAGE_ERASE, 24'h000100, 1, 9'h0, 8'h0, 3'h0);
		check(statusByte, 8'h01);
		wait_idle();
		chk_mem(0);
		cmd(CMD_WRITE_LATCH_SET, 24'h0, 0, 9'h0, 8'h0, 3'h0);
		cmd(CMD_SECTOR_ERASE, 24'h000000, 1, 9'h0, 8'h0, 3'h0);
		wait_idle();
		foreach (img[i]) img[i] = ERASED_BYTE;
		for (int i = 0; i < 16; i++) chk_mem(i);
		$display("done: program, count and erase");
		cmd(CMD_DEEP_SLEEP, 24'h0, 0, 9'h0, 8'h0, 3'h0);
		check({7'h0, deepSleep}, 8'h01);
		read_status(1, 8'hff);
		cmd(CMD_WRITE_LATCH_SET, 24'h0, 0, 9'h0, 8'h0, 3'h0);
		cmd(CMD_WAKE, 24'h0, 0, 9'h0, 8'h0, 3'h0);
		check({7'h0, deepSleep}, 8'h00);
		read_status(1, 8'h00);
		cmd(CMD_WRITE_LATCH_SET, 24'h0, 0, 9'h0, 8'h0, 3'h0);
		resetPinN = 0;
		repeat (6) @(negedge mclk);
		resetPinN = 1;
		repeat (4) @(negedge mclk);
		check(statusByte, 8'h00);
		$display("done: sleep and reset pin");
		report_and_stop();
	end
endmodule // sfwc_tb
